// file: hdl/nvsc_regs.vh
// constants for the nvsram host-side access controller
`ifndef NVSC_REGS_VH
`define NVSC_REGS_VH
`define NVSC_ADDR_W 13
`define NVSC_DATA_W 8
`define NVSC_SEQ_A0 13'h0000
`define NVSC_SEQ_A1 13'h1555
`define NVSC_SEQ_A2 13'h0AAA
`define NVSC_SEQ_A3 13'h1FFF
`define NVSC_SEQ_A4 13'h10F0
`define NVSC_SEQ_STORE 13'h0F0F
`define NVSC_SEQ_RECALL 13'h0F0E
`define NVSC_CLK_MHZ 50
`define NVSC_CYC_NS 100
`define NVSC_CYC_CNT ((`NVSC_CYC_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_RECALL_US 20
`define NVSC_RECALL_CNT (`NVSC_RECALL_US * `NVSC_CLK_MHZ)
`define NVSC_STORE_MS 10
`define NVSC_STORE_CNT (`NVSC_STORE_MS * 1000 * `NVSC_CLK_MHZ)
`define NVSC_RESTORE_US 550
`define NVSC_RESTORE_CNT (`NVSC_RESTORE_US * `NVSC_CLK_MHZ)
`endif

// file: hdl/nvsc_timer.v
// down-counter that measures bus phases and transfer waits
module nvsc_timer #(
    parameter W = 24
) (
    input wire mclk_i,
    input wire srst_i,
    input wire ce_i,
    input wire load_i,
    input wire [W-1:0] count_i,
    output wire done_o
);
    reg [W-1:0] cnt_r;
    // load wins over count so back-to-back phases start clean
    always @(posedge mclk_i)
    begin
        if (srst_i)
            cnt_r <= {W{1'b0}};
        else if (ce_i)
        begin
            if (load_i)
                cnt_r <= count_i;
            else if (cnt_r != {W{1'b0}})
                cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end
    assign done_o = (cnt_r == {W{1'b0}});
endmodule

// file: hdl/nvsc_ctrl.v
// host controller driving an nvsram: reads, writes, software store and recall
// Operation
// - address stays stable until enables rise; data captured there
// - host keeps output enable high through every write
// - store needs reads 0000,1555,0AAA,1FFF,10F0,0F0F in order
// - recall needs reads 0000,1555,0AAA,1FFF,10F0,0F0E in order
// - write enable stays high for all six sequence reads
// - each sequence step is a chip-enable-controlled read
`include "nvsc_regs.vh"
module nvsc_ctrl #(
    parameter AW = `NVSC_ADDR_W,
    parameter DW = `NVSC_DATA_W,
    parameter STORE_CNT = `NVSC_STORE_CNT,
    parameter RESTORE_CNT = `NVSC_RESTORE_CNT
) (
    input wire mclk_i,
    input wire srst_i,
    input wire ce_i,
    // user command port
    input wire rd_req_i,
    input wire wr_req_i,
    input wire store_req_i,
    input wire recall_req_i,
    input wire [AW-1:0] addr_i,
    input wire [DW-1:0] wdata_i,
    output reg ready_o,
    output reg done_o,
    output reg [DW-1:0] rdata_o,
    // memory pins
    output reg mem_ce_n_o,
    output reg mem_we_n_o,
    output reg mem_oe_n_o,
    output reg [AW-1:0] mem_addr_o,
    output reg [DW-1:0] mem_dq_o,
    output reg mem_dq_oe_n_o,
    input wire [DW-1:0] mem_dq_i,
    input wire store_busy_line_n_i
);
    localparam TW = 24;
    localparam [TW-1:0] CYC = `NVSC_CYC_CNT;
    localparam [TW-1:0] RCL = `NVSC_RECALL_CNT;
    localparam [TW-1:0] STO = STORE_CNT;
    localparam [TW-1:0] RST = RESTORE_CNT;
    localparam [6:0] S_BOOT = 7'h01;
    localparam [6:0] S_IDLE = 7'h02;
    localparam [6:0] S_SETUP = 7'h04;
    localparam [6:0] S_ACT = 7'h08;
    localparam [6:0] S_GAP = 7'h10;
    localparam [6:0] S_WAIT = 7'h20;
    localparam [6:0] S_DONE = 7'h40;

    // sequence address by step; step 5 picks store or recall
    function [AW-1:0] seq_addr;
        input [2:0] step;
        input rcl;
        begin
            case (step)
                3'h0: seq_addr = `NVSC_SEQ_A0;
                3'h1: seq_addr = `NVSC_SEQ_A1;
                3'h2: seq_addr = `NVSC_SEQ_A2;
                3'h3: seq_addr = `NVSC_SEQ_A3;
                3'h4: seq_addr = `NVSC_SEQ_A4;
                default: seq_addr = rcl ? `NVSC_SEQ_RECALL : `NVSC_SEQ_STORE;
            endcase
        end
    endfunction

    reg [6:0] st_r;
    reg is_wr_r;
    reg is_seq_r;
    reg rcl_r;
    reg [2:0] step_r;
    reg [DW-1:0] wd_r;
    reg [AW-1:0] ad_r;
    reg tload_r;
    reg [TW-1:0] tval_r;
    wire tdone;
    wire busy_idle;

    nvsc_timer #(.W(TW)) u_tmr (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .load_i(tload_r),
        .count_i(tval_r),
        .done_o(tdone)
    );

    // busy line low means device is transferring; never start then
    assign busy_idle = store_busy_line_n_i;

    ////////////////////////////////////////////////////////////////////
    // main sequencer
    always @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            st_r <= S_BOOT;
            tload_r <= 1'b1;
            tval_r <= RST;
            ready_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= {DW{1'b0}};
            mem_ce_n_o <= 1'b1;
            mem_we_n_o <= 1'b1;
            mem_oe_n_o <= 1'b1;
            mem_addr_o <= {AW{1'b0}};
            mem_dq_o <= {DW{1'b0}};
            mem_dq_oe_n_o <= 1'b1;
            is_wr_r <= 1'b0;
            is_seq_r <= 1'b0;
            rcl_r <= 1'b0;
            step_r <= 3'h0;
            wd_r <= {DW{1'b0}};
            ad_r <= {AW{1'b0}};
        end
        else if (ce_i)
        begin
            tload_r <= 1'b0;
            done_o <= 1'b0;
            case (st_r)
                S_BOOT:
                begin
                    // device recalls on power-up; wait it out
                    if (tdone && !tload_r)
                    begin
                        st_r <= S_IDLE;
                        ready_o <= 1'b1;
                        step_r <= 3'h0;
                    end
                end
                S_IDLE:
                begin
                    if (busy_idle && (rd_req_i || wr_req_i || store_req_i || recall_req_i))
                    begin
                        ready_o <= 1'b0;
                        is_wr_r <= wr_req_i && !rd_req_i;
                        is_seq_r <= !rd_req_i && !wr_req_i;
                        rcl_r <= recall_req_i && !store_req_i;
                        step_r <= 3'h0;
                        ad_r <= addr_i;
                        wd_r <= wdata_i;
                        st_r <= S_SETUP;
                    end
                end
                S_SETUP:
                begin
                    // address settles with every enable high
                    mem_addr_o <= is_seq_r ? seq_addr(step_r, rcl_r) : ad_r;
                    mem_we_n_o <= 1'b1;
                    mem_oe_n_o <= 1'b1;
                    mem_dq_o <= wd_r;
                    mem_dq_oe_n_o <= is_wr_r ? 1'b0 : 1'b1;
                    tload_r <= 1'b1;
                    tval_r <= CYC;
                    st_r <= S_ACT;
                end
                S_ACT:
                begin
                    if (tload_r)
                    begin
                        mem_ce_n_o <= 1'b0;
                        mem_we_n_o <= !is_wr_r;
                        // sequence reads leave output enable high: valid anyway
                        mem_oe_n_o <= is_wr_r || is_seq_r;
                    end
                    else if (tdone)
                    begin
                        // sample before controls rise; data tracks address
                        if (!is_wr_r && !is_seq_r)
                            rdata_o <= mem_dq_i;
                        // chip enable rise ends write; address held
                        mem_ce_n_o <= 1'b1;
                        mem_we_n_o <= 1'b1;
                        mem_oe_n_o <= 1'b1;
                        tload_r <= 1'b1;
                        tval_r <= CYC;
                        st_r <= S_GAP;
                    end
                end
                S_GAP:
                begin
                    if (!tload_r && tdone)
                    begin
                        mem_dq_oe_n_o <= 1'b1;
                        if (is_seq_r && step_r != 3'h5)
                        begin
                            // back-to-back reads, nothing in between
                            step_r <= step_r + 3'h1;
                            st_r <= S_SETUP;
                        end
                        else if (is_seq_r)
                        begin
                            // device erases+programs or clears+loads now
                            tload_r <= 1'b1;
                            tval_r <= rcl_r ? RCL : STO;
                            st_r <= S_WAIT;
                        end
                        else
                            st_r <= S_DONE;
                    end
                end
                S_WAIT:
                begin
                    // no access until device transfer time elapses
                    if (!tload_r && tdone && busy_idle)
                    begin
                        step_r <= 3'h0;
                        st_r <= S_DONE;
                    end
                end
                S_DONE:
                begin
                    done_o <= 1'b1;
                    ready_o <= 1'b1;
                    st_r <= S_IDLE;
                end
                default:
                    st_r <= S_IDLE;
            endcase
        end
    end
    // the device floats its drivers once write enable falls; oe stays high here anyway
endmodule

// file: verif/nvsc_ctrl_sva.sv
// pin protocol checker for the nvsram host controller
module nvsc_ctrl_chk #(
    parameter int AW = 13
) (
    input wire mclk_i,
    input wire srst_i,
    input wire ready_o,
    input wire done_o,
    input wire mem_ce_n_o,
    input wire mem_we_n_o,
    input wire mem_oe_n_o,
    input wire [AW-1:0] mem_addr_o,
    input wire mem_dq_oe_n_o,
    input wire store_busy_line_n_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // write strobe sits inside the chip enable window
    a_we_in_ce: assert property (!mem_we_n_o |-> !mem_ce_n_o)
        else $error("we low outside ce");
    a_oe_in_write: assert property (!mem_we_n_o |-> mem_oe_n_o)
        else $error("oe low in write");
    a_dq_no_fight: assert property (!mem_dq_oe_n_o |-> mem_oe_n_o)
        else $error("dq driven with oe low");
    a_addr_hold: assert property (!mem_ce_n_o && !$past(mem_ce_n_o) |-> $stable(mem_addr_o))
        else $error("address moved in access");
    a_ce_strobe: assert property ($fell(mem_ce_n_o) |-> !mem_ce_n_o [*3] ##[1:20] mem_ce_n_o)
        else $error("bad ce strobe");
    // a strobe while the device is busy would be lost
    a_idle_busy: assert property ($fell(mem_ce_n_o) |-> store_busy_line_n_i)
        else $error("access while busy");
    a_done_idle: assert property (done_o |-> store_busy_line_n_i && mem_ce_n_o)
        else $error("done before transfer end");
    a_powerup_wait: assert property ($fell(srst_i) |-> !ready_o [*8])
        else $error("ready before powerup recall");
endmodule
bind nvsc_ctrl nvsc_ctrl_chk #(.AW(AW)) u_chk (.mclk_i(mclk_i), .srst_i(srst_i), .ready_o(ready_o),
    .done_o(done_o), .mem_ce_n_o(mem_ce_n_o), .mem_we_n_o(mem_we_n_o),
    .mem_oe_n_o(mem_oe_n_o), .mem_addr_o(mem_addr_o), .mem_dq_oe_n_o(mem_dq_oe_n_o),
    .store_busy_line_n_i(store_busy_line_n_i));

// file: verif/nvsc_mem_model.sv
// behavioural nvsram with software store and recall
module nvsc_mem_model #(
    parameter int ST_CYC = 40,
    parameter int RC_CYC = 30
) (
    input wire logic clk_i,
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic [12:0] addr_i,
    input wire logic [7:0] dq_i,
    output logic [7:0] dq_o,
    output logic busy_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sram [0:8191];
    logic [7:0] nv [0:8191];
    logic [12:0] seq [0:4];
    logic [12:0] addr_q;
    logic [7:0] last_q;
    logic [2:0] step;
    logic we_q, ce_q;
    int cnt;
    ////////////////////////////////////////////////////////////////////////////////
    // power-up recall keeps the device busy at first
    initial
    begin
        foreach (sram[i]) sram[i] = 8'(i);
        seq = '{13'h0000, 13'h1555, 13'h0AAA, 13'h1FFF, 13'h10F0};
        busy_n_o = 1'b0;
        cnt = 10;
        step = 3'd0;
        ce_q = 1'b1;
        last_q = 8'hA5;
    end
    // no pull-up: an idle bus shows the inverse so stale data cannot pass
    assign dq_o = (!ce_n_i && !oe_n_i && we_n_i && busy_n_o) ? sram[addr_i] : ~last_q;
    // accesses, sequence detection and transfers
    always @(posedge clk_i)
    begin
        ce_q <= ce_n_i;
        we_q <= we_n_i;
        addr_q <= addr_i;
        if (!ce_n_i && !oe_n_i && we_n_i && busy_n_o) last_q <= sram[addr_i];
        if (!busy_n_o)
        begin
            cnt <= cnt - 1;
            if (cnt <= 1) busy_n_o <= 1'b1;
        end
        else if (!ce_n_i && !we_n_i) sram[addr_i] <= dq_i;
        else if (ce_n_i && !ce_q)
        begin
            if (!we_q) step <= 3'd0;
            else if (step == 3'd5 && (addr_q == 13'h0F0F || addr_q == 13'h0F0E))
            begin
                step <= 3'd0;
                busy_n_o <= 1'b0;
                if (addr_q[0])
                begin
                    foreach (nv[i]) nv[i] <= sram[i];
                    cnt <= ST_CYC;
                end
                else
                begin
                    foreach (sram[i]) sram[i] <= nv[i];
                    cnt <= RC_CYC;
                end
            end
            else if (step < 3'd5 && addr_q == seq[step]) step <= step + 3'd1;
            else step <= {2'b00, addr_q == 13'h0000};
        end
    end
endmodule

// file: verif/nvsc_ctrl_test.sv
// self-checking bench for the nvsram host controller
module nvsc_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 0, srst_i = 1, ce_i = 1, rd_req_i = 0, wr_req_i = 0;
    logic store_req_i = 0, recall_req_i = 0;
    logic [12:0] addr_i = 13'h0000;
    logic [7:0] wdata_i = 8'h00;
    wire ready_o, done_o, mem_ce_n_o, mem_we_n_o, mem_oe_n_o, mem_dq_oe_n_o, busy_n;
    wire [7:0] rdata_o, mem_dq_o, dev_q, dq_bus;
    wire [12:0] mem_addr_o;
    int errors = 0, num_checks = 0;
    ////////////////////////////////////////////////////////////////////////////////
    always #10 mclk_i = ~mclk_i;
    // the byte lane carries the host only while it enables its drivers
    assign dq_bus = mem_dq_oe_n_o ? dev_q : mem_dq_o;
    nvsc_ctrl #(.STORE_CNT(20), .RESTORE_CNT(20)) uut (.mclk_i(mclk_i), .srst_i(srst_i),
        .ce_i(ce_i), .rd_req_i(rd_req_i), .wr_req_i(wr_req_i), .store_req_i(store_req_i),
        .recall_req_i(recall_req_i), .addr_i(addr_i), .wdata_i(wdata_i), .ready_o(ready_o),
        .done_o(done_o), .rdata_o(rdata_o), .mem_ce_n_o(mem_ce_n_o), .mem_we_n_o(mem_we_n_o),
        .mem_oe_n_o(mem_oe_n_o), .mem_addr_o(mem_addr_o), .mem_dq_o(mem_dq_o),
        .mem_dq_oe_n_o(mem_dq_oe_n_o), .mem_dq_i(dq_bus), .store_busy_line_n_i(busy_n));
    nvsc_mem_model mdl (.clk_i(mclk_i), .ce_n_i(mem_ce_n_o), .we_n_i(mem_we_n_o),
        .oe_n_i(mem_oe_n_o), .addr_i(mem_addr_o), .dq_i(dq_bus), .dq_o(dev_q), .busy_n_o(busy_n));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // kind is {rd, wr, store, recall}; held until the taking edge only
    task automatic op(input logic [3:0] kind, input logic [12:0] a, input logic [7:0] d);
        int n;
        n = 0;
        {rd_req_i, wr_req_i, store_req_i, recall_req_i} <= kind;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        {rd_req_i, wr_req_i, store_req_i, recall_req_i} <= 4'h0;
        while (done_o !== 1'b1 && n < 3000)
        begin
            @(posedge mclk_i);
            n++;
        end
        chk("done", 8'h01, {7'h00, done_o});
    endtask
    task automatic t_rw;
        op(4'h4, 13'h1FFF, 8'hC3);
        op(4'h8, 13'h1FFF, 8'h00);
        chk("read 1fff", 8'hC3, rdata_o);
        op(4'h8, 13'h0124, 8'h00);
        chk("read 0124", 8'h24, rdata_o);
        $display("test rw finished");
    endtask
    // clock enable low must freeze the idle controller with a request standing
    task automatic t_freeze;
        ce_i <= 1'b0;
        rd_req_i <= 1'b1;
        addr_i <= 13'h0003;
        repeat (4) @(posedge mclk_i);
        chk("frozen ready", 8'h01, {7'h00, ready_o});
        chk("frozen ce", 8'h01, {7'h00, mem_ce_n_o});
        ce_i <= 1'b1;
        rd_req_i <= 1'b0;
        @(posedge mclk_i);
        op(4'h8, 13'h0003, 8'h00);
        chk("read 0003", 8'h03, rdata_o);
        $display("test freeze finished");
    endtask
    task automatic t_store;
        op(4'h4, 13'h0040, 8'h3C);
        op(4'h2, 13'h0000, 8'h00);
        chk("nv 0040", 8'h3C, mdl.nv[64]);
        op(4'h8, 13'h0040, 8'h00);
        chk("after store", 8'h3C, rdata_o);
        $display("test store finished");
    endtask
    task automatic t_recall;
        op(4'h4, 13'h0040, 8'hC5);
        repeat (2)
        begin
            op(4'h1, 13'h0000, 8'h00);
            op(4'h8, 13'h0040, 8'h00);
            chk("recalled", 8'h3C, rdata_o);
            chk("nv kept", 8'h3C, mdl.nv[64]);
        end
        $display("test recall finished");
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // reset, power-up wait, then the scenarios
    initial
    begin
        int n;
        n = 0;
        repeat (3) @(posedge mclk_i);
        srst_i <= 1'b0;
        while (ready_o !== 1'b1 && n < 200)
        begin
            @(posedge mclk_i);
            n++;
        end
        chk("powerup wait", 8'h01, {7'h00, n >= 20});
        t_rw();
        t_freeze();
        t_store();
        t_recall();
        print_verdict();
    end
    // whole run is under three thousand cycles; this cuts a hang at 20000
    initial
    begin
        #400000;
        errors++;
        print_verdict();
    end
endmodule
